// ==== rpm_mode_decode.sv ====
// module: one regulator mode decoder, registered enable and low-power outputs
`timescale 1ns/100ps

module rpm_mode_decode
    import rpm_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic [1:0] mode_sel,    // 2-bit operating-mode field
    input  wire logic       seq_member,  // part of a flexible power sequence
    input  wire logic       seq_on,      // selected sequencer enabled
    input  wire logic       glp,         // global low-power signal
    output logic            en_reg,      // regulator enabled
    output logic            lp_reg       // 1 low-power, 0 normal
);

    logic en_next;   // decoded enable
    logic lp_next;   // decoded low-power selection

    // decode: off code wins over everything, sequencer gates members only;
    // forced normal simply leaves the low-power select clear
    always_comb begin
        en_next = (mode_sel != RPM_MODE_OFF) &&
                  (!seq_member || seq_on);
        lp_next = en_next && ((mode_sel == RPM_MODE_LP) ||
                              ((mode_sel == RPM_MODE_GRP) && glp));
    end

    // register outputs so the regulator pins never see decode glitches
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            en_reg <= 1'b0;
            lp_reg <= 1'b0;
        end else begin
            en_reg <= en_next;
            lp_reg <= lp_next;
        end
    end

endmodule : rpm_mode_decode

// ==== rpm_pkg.sv ====
// package: register map, field layout, reset values and slot table for power-mode control
package rpm_pkg;

    // ******************************************************
    // register indices (byte address is four times index)
    // ******************************************************
    localparam logic [7:0] RPM_IDX_GLBL      = 8'h91; // global control, low-power bit
    localparam logic [7:0] RPM_IDX_SLEEP     = 8'h96; // sleep_slot_timing
    localparam logic [7:0] RPM_IDX_BUCK      = 8'h97; // buck_mode_select
    localparam logic [7:0] RPM_IDX_LIN_LO    = 8'h98; // linear_mode_select_low
    localparam logic [7:0] RPM_IDX_LIN_HI    = 8'h99; // linear_mode_select_high
    localparam logic [7:0] RPM_IDX_STAT_BUCK = 8'ha0; // buck enable/low-power status
    localparam logic [7:0] RPM_IDX_STAT_LEN  = 8'ha1; // linear enable status
    localparam logic [7:0] RPM_IDX_STAT_LLP  = 8'ha2; // linear low-power status

    // ******************************************************
    // field layout
    // ******************************************************
    localparam int RPM_ADDR_W       = 10;   // byte address width
    localparam int RPM_IDX_LSB      = 2;    // word index starts above byte lanes
    localparam int RPM_GLP_BIT      = 4;    // global low-power bit in global control
    localparam int RPM_ENTRY_MSB    = 6;    // sleep-entry slot period 6:4
    localparam int RPM_ENTRY_LSB    = 4;
    localparam int RPM_EXIT_MSB     = 2;    // sleep-exit slot period 2:0
    localparam int RPM_EXIT_LSB     = 0;
    localparam int RPM_RSVD_HI_BIT  = 7;    // reserved bits of sleep timing
    localparam int RPM_RSVD_LO_BIT  = 3;
    localparam int RPM_NUM_BUCK     = 4;
    localparam int RPM_NUM_LIN      = 8;
    localparam int RPM_NUM_DEC      = 12;   // decoders: bucks then linears
    localparam logic [7:0] RPM_SLEEP_WMASK = 8'h77; // reserved bits never stored

    // ******************************************************
    // factory-programmed reset values
    // ******************************************************
    localparam logic [7:0] RPM_RST_GLBL   = 8'h00;
    localparam logic [7:0] RPM_RST_SLEEP  = 8'h00;
    localparam logic [7:0] RPM_RST_BUCK   = 8'h00;
    localparam logic [7:0] RPM_RST_LIN_LO = 8'h00;
    localparam logic [7:0] RPM_RST_LIN_HI = 8'h00;

    // ******************************************************
    // mode codes and sequencer source codes
    // ******************************************************
    localparam logic [1:0] RPM_MODE_OFF  = 2'h0; // output disabled
    localparam logic [1:0] RPM_MODE_GRP  = 2'h1; // follow global low-power signal
    localparam logic [1:0] RPM_MODE_LP   = 2'h2; // forced low-power
    localparam logic [1:0] RPM_MODE_NORM = 2'h3; // forced normal
    localparam logic [1:0] RPM_SRC_SEQ0  = 2'h0; // flexible_power_sequencer 0
    localparam logic [1:0] RPM_SRC_NONE  = 2'h3; // not in any sequence

    // ******************************************************
    // bus answers
    // ******************************************************
    localparam logic [1:0] RPM_RESP_OKAY   = 2'h0;
    localparam logic [1:0] RPM_RESP_SLVERR = 2'h2;

    // ******************************************************
    // slot period table, microseconds 31 63 127 253 508 984 1936 3904
    // ******************************************************
    localparam logic [11:0] RPM_SLOT_US [8] = '{
        12'h01f, 12'h03f, 12'h07f, 12'h0fd, 12'h1fc, 12'h3d8, 12'h790, 12'hf40
    };

endpackage : rpm_pkg

// ==== rpm_power_mode_ctrl.sv ====
// module: regulator power-mode control bank behind an AXI4-Lite slave
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps

module rpm_power_mode_ctrl
    import rpm_pkg::*;
(
    input  wire logic                  sys_clk,
    input  wire logic                  rst_n,
    // ******************************************************
    // AXI4-Lite slave
    // ******************************************************
    input  wire logic [RPM_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [RPM_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    // ******************************************************
    // sequencer side, same clock domain
    // ******************************************************
    input  wire logic [15:0]           linear_sequencer_source, // 2 bits per regulator
    input  wire logic [1:0]            seq_enable,              // sequencer 0 and 1
    // ******************************************************
    // regulator controls
    // ******************************************************
    output logic [3:0]                 buck_en,
    output logic [3:0]                 buck_lp,
    output logic [7:0]                 linear_en,
    output logic [7:0]                 linear_lp,
    output logic                       global_low_power,
    output logic [11:0]                sleep_entry_period_us,
    output logic [11:0]                sleep_exit_period_us
);

    // ******************************************************
    // storage
    // ******************************************************
    logic [7:0]  glbl_reg;          // global control
    logic [7:0]  sleep_reg;         // sleep_slot_timing
    logic [7:0]  buck_reg;          // buck_mode_select
    logic [7:0]  lin_lo_reg;        // linear_mode_select_low
    logic [7:0]  lin_hi_reg;        // linear_mode_select_high
    logic [11:0] entry_us_reg;      // decoded sleep-entry period
    logic [11:0] exit_us_reg;       // decoded sleep-exit period

    // bus side holding registers
    logic        aw_full_reg;       // write address held
    logic [7:0]  aw_idx_reg;        // held write word index
    logic        w_full_reg;        // write data held
    logic [7:0]  w_data_reg;        // held low byte
    logic        w_lane_reg;        // held strobe of byte 0
    logic        bvalid_reg;
    logic [1:0]  bresp_reg;
    logic        rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0]  rresp_reg;

    logic        do_write;          // both halves present, response slot free
    logic        wr_hit;            // held index is writable
    logic [7:0]  ar_idx;            // read word index
    logic [31:0] rd_word;           // read mux
    logic        rd_hit;            // read index mapped

    // decoder wiring, bucks 0..3 then linears 0..7
    logic [1:0]  dec_mode   [RPM_NUM_DEC];
    logic        dec_member [RPM_NUM_DEC];
    logic        dec_seq_on [RPM_NUM_DEC];
    logic [RPM_NUM_DEC-1:0] dec_en;
    logic [RPM_NUM_DEC-1:0] dec_lp;
    logic [1:0]  lin_src    [RPM_NUM_LIN];

    // ******************************************************
    // write channel: address and data taken in either order
    // ******************************************************
    assign s_axi_awready = !aw_full_reg;
    assign s_axi_wready  = !w_full_reg;
    assign do_write      = aw_full_reg && w_full_reg && !bvalid_reg;

    // mapped writable indices; status words ignore writes with an error
    always_comb begin
        case (aw_idx_reg)
            RPM_IDX_GLBL, RPM_IDX_SLEEP, RPM_IDX_BUCK,
            RPM_IDX_LIN_LO, RPM_IDX_LIN_HI: wr_hit = 1'b1;
            default:                        wr_hit = 1'b0;
        endcase
    end

    // address holding register
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            aw_full_reg <= 1'b0;
            aw_idx_reg  <= 8'h00;
        end else if (s_axi_awvalid && !aw_full_reg) begin
            aw_full_reg <= 1'b1;
            aw_idx_reg  <= s_axi_awaddr[RPM_IDX_LSB +: 8];
        end else if (do_write) begin
            aw_full_reg <= 1'b0;
        end
    end

    // data holding register, only byte lane 0 carries register bits
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            w_full_reg <= 1'b0;
            w_data_reg <= 8'h00;
            w_lane_reg <= 1'b0;
        end else if (s_axi_wvalid && !w_full_reg) begin
            w_full_reg <= 1'b1;
            w_data_reg <= s_axi_wdata[7:0];
            w_lane_reg <= s_axi_wstrb[0];
        end else if (do_write) begin
            w_full_reg <= 1'b0;
        end
    end

    // write response, one outstanding at most
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= RPM_RESP_OKAY;
        end else if (do_write) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wr_hit ? RPM_RESP_OKAY : RPM_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp  = bresp_reg;

    // ******************************************************
    // register file
    // ******************************************************
    // mode fields load factory values at reset and keep what was written
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            glbl_reg   <= RPM_RST_GLBL;
            sleep_reg  <= RPM_RST_SLEEP;
            buck_reg   <= RPM_RST_BUCK;
            lin_lo_reg <= RPM_RST_LIN_LO;
            lin_hi_reg <= RPM_RST_LIN_HI;
        end else if (do_write && w_lane_reg) begin
            case (aw_idx_reg)
                RPM_IDX_GLBL:   glbl_reg   <= w_data_reg;
                // reserved bits dropped so a careless write cannot stick
                RPM_IDX_SLEEP:  sleep_reg  <= w_data_reg & RPM_SLEEP_WMASK;
                RPM_IDX_BUCK:   buck_reg   <= w_data_reg;
                RPM_IDX_LIN_LO: lin_lo_reg <= w_data_reg;
                RPM_IDX_LIN_HI: lin_hi_reg <= w_data_reg;
                default:        ;
            endcase
        end
    end

    // slot period lookup, table index is the 3-bit code
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            entry_us_reg <= RPM_SLOT_US[0];
            exit_us_reg  <= RPM_SLOT_US[0];
        end else begin
            entry_us_reg <= RPM_SLOT_US[sleep_reg[RPM_ENTRY_MSB:RPM_ENTRY_LSB]];
            exit_us_reg  <= RPM_SLOT_US[sleep_reg[RPM_EXIT_MSB:RPM_EXIT_LSB]];
        end
    end

    assign sleep_entry_period_us = entry_us_reg;
    assign sleep_exit_period_us  = exit_us_reg;
    assign global_low_power      = glbl_reg[RPM_GLP_BIT];

    // ******************************************************
    // read channel
    // ******************************************************
    assign s_axi_arready = !rvalid_reg;
    assign ar_idx        = s_axi_araddr[RPM_IDX_LSB +: 8];

    // read mux; status words show the live decoder outputs
    always_comb begin
        rd_hit  = 1'b1;
        rd_word = 32'h0000_0000;
        case (ar_idx)
            RPM_IDX_GLBL:      rd_word[7:0] = glbl_reg;
            RPM_IDX_SLEEP:     rd_word[7:0] = sleep_reg;
            RPM_IDX_BUCK:      rd_word[7:0] = buck_reg;
            RPM_IDX_LIN_LO:    rd_word[7:0] = lin_lo_reg;
            RPM_IDX_LIN_HI:    rd_word[7:0] = lin_hi_reg;
            RPM_IDX_STAT_BUCK: rd_word[7:0] = {buck_lp, buck_en};
            RPM_IDX_STAT_LEN:  rd_word[7:0] = linear_en;
            RPM_IDX_STAT_LLP:  rd_word[7:0] = linear_lp;
            default:           rd_hit = 1'b0;
        endcase
    end

    // read answer registered on the same edge that takes the address
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0000_0000;
            rresp_reg  <= RPM_RESP_OKAY;
        end else if (s_axi_arvalid && !rvalid_reg) begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= rd_word;
            rresp_reg  <= rd_hit ? RPM_RESP_OKAY : RPM_RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata  = rdata_reg;
    assign s_axi_rresp  = rresp_reg;

    // ******************************************************
    // decoder input steering
    // ******************************************************
    // bucks are never sequencer members, linears use their source code
    always_comb begin
        for (int i = 0; i < RPM_NUM_LIN; i++) begin
            lin_src[i] = linear_sequencer_source[2*i +: 2];
        end
        for (int i = 0; i < RPM_NUM_BUCK; i++) begin
            dec_mode[i]   = buck_reg[2*i +: 2];
            dec_member[i] = 1'b0;
            dec_seq_on[i] = 1'b0;
        end
        // linear 0 sits in the top field, linear 3 in the bottom one
        for (int i = 0; i < RPM_NUM_LIN / 2; i++) begin
            dec_mode[RPM_NUM_BUCK + i]     = lin_lo_reg[6 - 2*i +: 2];
            dec_mode[RPM_NUM_BUCK + 4 + i] = lin_hi_reg[6 - 2*i +: 2];
        end
        for (int i = 0; i < RPM_NUM_LIN; i++) begin
            dec_member[RPM_NUM_BUCK + i] = (lin_src[i] != RPM_SRC_NONE);
            // codes 01 and 10 both select sequencer 1
            dec_seq_on[RPM_NUM_BUCK + i] = (lin_src[i] == RPM_SRC_SEQ0) ?
                                           seq_enable[0] : seq_enable[1];
        end
    end

    // ******************************************************
    // mode decoders
    // ******************************************************
    for (genvar gi = 0; gi < RPM_NUM_DEC; gi++) begin : g_dec
        rpm_mode_decode u_dec (
            .sys_clk    (sys_clk),
            .rst_n      (rst_n),
            .mode_sel   (dec_mode[gi]),
            .seq_member (dec_member[gi]),
            .seq_on     (dec_seq_on[gi]),
            .glp        (glbl_reg[RPM_GLP_BIT]),
            .en_reg     (dec_en[gi]),
            .lp_reg     (dec_lp[gi])
        );
    end

    assign buck_en   = dec_en[RPM_NUM_BUCK-1:0];
    assign buck_lp   = dec_lp[RPM_NUM_BUCK-1:0];
    assign linear_en = dec_en[RPM_NUM_DEC-1:RPM_NUM_BUCK];
    assign linear_lp = dec_lp[RPM_NUM_DEC-1:RPM_NUM_BUCK];

    // ******************************************************
    // assertions
    // ******************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // an off code committed to buck 0, seen at the pin two edges later
    sequence s_buck_off_write;
        do_write && w_lane_reg && (aw_idx_reg == RPM_IDX_BUCK) &&
        (w_data_reg[1:0] == RPM_MODE_OFF);
    endsequence
    sequence s_buck_off_seen;
        ##2 !buck_en[0];
    endsequence
    AST_SLOT_ENTRY: assert property (
        ##1 entry_us_reg == RPM_SLOT_US[$past(sleep_reg[RPM_ENTRY_MSB:RPM_ENTRY_LSB])])
        else $error("sleep entry period decode wrong");
    AST_RSVD_ZERO: assert property (
        !sleep_reg[RPM_RSVD_HI_BIT] && !sleep_reg[RPM_RSVD_LO_BIT])
        else $error("reserved sleep timing bit stored");
    AST_BUCK_OFF: assert property (
        s_buck_off_write |-> s_buck_off_seen)
        else $error("buck 0 not off two edges after off write");

    AST_BUCK_GRP: assert property (
        buck_reg[1:0] == RPM_MODE_GRP |=>
        buck_en[0] && (buck_lp[0] == $past(global_low_power)))
        else $error("buck 0 not following global low-power");

    AST_LIN_OFF: assert property (
        lin_lo_reg[7:6] == RPM_MODE_OFF |=> !linear_en[0] && !linear_lp[0])
        else $error("linear 0 on with off code");

    AST_LIN_FREE_GRP: assert property (
        lin_src[0] == RPM_SRC_NONE && lin_lo_reg[7:6] == RPM_MODE_GRP |=>
        linear_en[0] && (linear_lp[0] == $past(global_low_power)))
        else $error("unsequenced linear 0 group mode wrong");

    AST_LIN_FREE_LP: assert property (
        lin_src[0] == RPM_SRC_NONE && lin_lo_reg[7:6] == RPM_MODE_LP |=>
        linear_en[0] && linear_lp[0])
        else $error("unsequenced linear 0 not forced low-power");

    AST_LIN_FREE_NORM: assert property (
        lin_src[0] == RPM_SRC_NONE && lin_lo_reg[7:6] == RPM_MODE_NORM |=>
        linear_en[0] && !linear_lp[0])
        else $error("unsequenced linear 0 not forced normal");

    AST_SEQ_GATES_OFF: assert property (
        lin_src[0] != RPM_SRC_NONE && !dec_seq_on[RPM_NUM_BUCK] |=> !linear_en[0])
        else $error("sequenced linear 0 on with sequencer off");

    AST_SEQ_GRP: assert property (
        lin_src[0] != RPM_SRC_NONE && dec_seq_on[RPM_NUM_BUCK] &&
        lin_lo_reg[7:6] == RPM_MODE_GRP |=>
        linear_en[0] && (linear_lp[0] == $past(global_low_power)))
        else $error("sequenced linear 0 group mode wrong");

    AST_SEQ_LP: assert property (
        lin_src[0] != RPM_SRC_NONE && dec_seq_on[RPM_NUM_BUCK] &&
        lin_lo_reg[7:6] == RPM_MODE_LP |=> linear_en[0] && linear_lp[0])
        else $error("sequenced linear 0 not low-power");

    AST_SEQ_NORM: assert property (
        lin_src[0] != RPM_SRC_NONE && dec_seq_on[RPM_NUM_BUCK] &&
        lin_lo_reg[7:6] == RPM_MODE_NORM |=> linear_en[0] && !linear_lp[0])
        else $error("sequenced linear 0 not normal");

    AST_GLP_FOLLOW: assert property (
        $rose(global_low_power) && buck_reg[7:6] == RPM_MODE_GRP |=> buck_lp[3])
        else $error("buck 3 ignored rising global low-power");

    AST_WRITE_READBACK: assert property (
        do_write && w_lane_reg && aw_idx_reg == RPM_IDX_LIN_HI |=>
        lin_hi_reg == $past(w_data_reg))
        else $error("linear high mode write lost");

    AST_SEQ_DROP: assert property (
        $fell(seq_enable[1]) && lin_src[7] == 2'h1 && $past(lin_src[7]) == 2'h1 |=>
        !linear_en[7])
        else $error("linear 7 slow to drop with sequencer");
endmodule : rpm_power_mode_ctrl

// ==== rpm_power_mode_ctrl_bench.sv ====
// testbench: register bus and decoder checks of the power-mode control bank
`timescale 1ns/100ps
module rpm_power_mode_ctrl_bench;
    import rpm_pkg::*;
    // ****
    // stimulus and observed signals
    // ****
    logic        sys_clk = 0, rst_n = 0;           // clock, reset low at start
    logic [9:0]  awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic        awready, wready, bvalid, arready, rvalid, glp_o;
    logic [1:0]  bresp, rresp, sen = '0;          // sen: sequencer enables
    logic [15:0] src = '0;                         // sequencer source per linear
    logic [3:0]  buck_en, buck_lp;
    logic [7:0]  linear_en, linear_lp;
    logic [11:0] pent, pext;
    logic [3:0]  strb = 4'hf;                      // write strobes
    logic [7:0]  rst_val [4] = '{RPM_RST_SLEEP, RPM_RST_BUCK, RPM_RST_LIN_LO, RPM_RST_LIN_HI};
    int          err_total = 0, checks_done = 0, seed = 32'h25b49597;
    rpm_power_mode_ctrl i_rpm_power_mode_ctrl (.sys_clk(sys_clk), .rst_n(rst_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .linear_sequencer_source(src),
        .seq_enable(sen), .buck_en(buck_en), .buck_lp(buck_lp), .linear_en(linear_en),
        .linear_lp(linear_lp), .global_low_power(glp_o),
        .sleep_entry_period_us(pent), .sleep_exit_period_us(pext));
    initial forever #10 sys_clk = ~sys_clk;        // 50 MHz
    initial begin
        #400000;                                   // 20,000 cycles, about thirteen times the expected run
        err_total++;
        complete_run;
    end
    // ****
    // helpers
    // ****
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : complete_run
    task automatic chk(input string n, input logic [31:0] e, g);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // readies sampled at the falling edge, where they have settled
    task automatic wr(input logic [7:0] i, d, output logic [1:0] r);
        logic a, w, b;
        b = 0;
        @(posedge sys_clk);
        awaddr <= {i, 2'b00};
        wdata <= {24'h0, d};
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        for (int t = 0; t < 100 && !b; t++) begin
            @(negedge sys_clk);
            a = awvalid && awready;
            w = wvalid && wready;
            b = bvalid;
            r = bresp;
            @(posedge sys_clk);
            if (a) awvalid <= 0;
            if (w) wvalid <= 0;
        end
        bready <= 0;
        if (!b) err_total++;
    endtask : wr
    task automatic rd(input logic [7:0] i, output logic [31:0] d, output logic [1:0] r);
        logic a, v;
        v = 0;
        @(posedge sys_clk);
        araddr <= {i, 2'b00};
        arvalid <= 1;
        rready <= 1;
        for (int t = 0; t < 100 && !v; t++) begin
            @(negedge sys_clk);
            a = arvalid && arready;
            v = rvalid;
            d = rdata;
            r = rresp;
            @(posedge sys_clk);
            if (a) arvalid <= 0;
        end
        rready <= 0;
        if (!v) err_total++;
    endtask : rd
    task automatic rw(input logic [7:0] i, d, e);
        logic [1:0] r;
        logic [31:0] q;
        wr(i, d, r);
        chk("bresp", RPM_RESP_OKAY, r);
        rd(i, q, r);
        chk("rresp", RPM_RESP_OKAY, r);
        chk("rdata", {24'h0, e}, q);
    endtask : rw
    // expected {enable, low-power} of one regulator
    function automatic logic [1:0] dec(input logic [1:0] m, s, input logic g, lin);
        logic on;
        on = !lin || s == RPM_SRC_NONE || (s == RPM_SRC_SEQ0 ? sen[0] : sen[1]);
        if (m == RPM_MODE_OFF || !on) return 2'b00;
        return {1'b1, m == RPM_MODE_LP || (m == RPM_MODE_GRP && g)};
    endfunction : dec
    // outputs are looked at one edge after their causes
    task automatic chk_out(input logic [7:0] bk, lo, hi, input logic g);
        logic [1:0] e;
        @(posedge sys_clk);
        #1;
        chk("global_low_power", g, glp_o);
        for (int i = 0; i < 4; i++) begin
            e = dec(bk[2*i+:2], RPM_SRC_NONE, g, 0);
            chk("buck_en", e[1], buck_en[i]);
            chk("buck_lp", e[0], buck_lp[i]);
        end
        for (int i = 0; i < 8; i++) begin
            e = dec(i < 4 ? lo[6-2*i+:2] : hi[14-2*i+:2], src[2*i+:2], g, 1);
            chk("linear_en", e[1], linear_en[i]);
            chk("linear_lp", e[0], linear_lp[i]);
        end
    endtask : chk_out
    // factory values after any reset, every regulator off
    task automatic chk_rst;
        logic [31:0] q;
        logic [1:0] r;
        for (int k = 0; k < 4; k++) begin
            rd(RPM_IDX_SLEEP + 8'(k), q, r);
            chk("reset_value", {24'h0, rst_val[k]}, q);
        end
        chk("entry_reset", RPM_SLOT_US[RPM_RST_SLEEP[6:4]], pent);
        chk("exit_reset", RPM_SLOT_US[RPM_RST_SLEEP[2:0]], pext);
        chk_out(RPM_RST_BUCK, RPM_RST_LIN_LO, RPM_RST_LIN_HI, RPM_RST_GLBL[4]);
    endtask : chk_rst
    // ****
    // tests
    // ****
    initial begin
        logic [31:0] q;
        logic [1:0] r;
        logic [7:0] bk, lo, hi;
        logic g;
        repeat (12) @(posedge sys_clk);
        rst_n <= 1;
        chk_rst;
        $display("reset test done");
        // every slot code, reserved bits kept at zero as software must
        for (int c = 0; c < 8; c++) begin
            rw(RPM_IDX_SLEEP, 8'(c << 4) | 8'(7 - c), 8'(c << 4) | 8'(7 - c));
            chk("entry_period", RPM_SLOT_US[c], pent);
            chk("exit_period", RPM_SLOT_US[7-c], pext);
        end
        $display("slot period test done");
        for (int n = 0; n < 48; n++) begin
            bk = 8'($random(seed));
            lo = 8'($random(seed));
            hi = 8'($random(seed));
            g = 1'($random(seed));
            @(posedge sys_clk);
            src <= (n % 4 == 0) ? 16'hffff : 16'($random(seed));
            sen <= (n < 4) ? 2'(n) : 2'($random(seed));
            wr(RPM_IDX_GLBL, {3'h0, g, 4'h0}, r);
            rw(RPM_IDX_BUCK, bk, bk);
            rw(RPM_IDX_LIN_LO, lo, lo);
            rw(RPM_IDX_LIN_HI, hi, hi);
            chk_out(bk, lo, hi, g);
            @(posedge sys_clk);
            sen <= ~sen;
            chk_out(bk, lo, hi, g);
        end
        $display("decode test done");
        strb <= 4'h0;                              // byte lane 0 off, write dropped
        rw(RPM_IDX_BUCK, ~bk, bk);
        strb <= 4'hf;
        rd(8'hff, q, r);
        chk("rresp_unmapped", RPM_RESP_SLVERR, r);
        chk("rdata_unmapped", 32'h0, q);
        wr(RPM_IDX_STAT_LEN, 8'hff, r);
        chk("bresp_status", RPM_RESP_SLVERR, r);
        $display("strobe and error answer test done");
        @(posedge sys_clk);
        rst_n <= 0;                                // reset in mid-run, bus idle
        repeat (2) @(posedge sys_clk);
        rst_n <= 1;
        chk_rst;
        $display("mid-run reset test done");
        complete_run;
    end
endmodule : rpm_power_mode_ctrl_bench
